// *** core/rm_map.svh ***
// address map, field positions, reset values and timing of the rate match fifo
`ifndef RM_MAP_SVH
`define RM_MAP_SVH
`define RM_LANES 4
`define RM_IDLE_CODE 8'h1c
`define RM_CLK_PERIOD_NS 8'h0a
`define RM_LINK_PERIOD_NS 8'h7d
`define RM_FIFO_DEPTH 16
`define RM_REG_CTRL 12'h000
`define RM_REG_STATUS 12'h004
`define RM_REG_WMARK 12'h008
`define RM_REG_DEL_CNT 12'h00c
`define RM_REG_INS_CNT 12'h010
`define RM_CTRL_EN 0
`define RM_CTRL_EN_RESET 1'h1
`define RM_WM_HIGH_LSB 0
`define RM_WM_LOW_LSB 8
`define RM_WM_HIGH_RESET 5'h0c
`define RM_WM_LOW_RESET 5'h04
`define RM_PRIME_LEVEL 5'h08
`define RM_ST_FULL 0
`define RM_ST_EMPTY 1
`define RM_ST_STATE_LSB 2
`define RM_ST_ALIGNED 4
`define RM_ST_LEVEL_LSB 8
`endif

// *** core/rm_pkg.sv ***
// types shared by the rate match fifo design
package rm_pkg;
  typedef enum logic [1:0] {
    st_wait_align = 2'b00,
    st_priming = 2'b01,
    st_matching = 2'b10,
    st_halted = 2'b11
  } rm_state_t;
endpackage : rm_pkg

// *** core/rm_column_fifo.sv ***
// column fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module rm_column_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clear,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [LW-1:0] count;
  } fifo_regs_t;
  fifo_regs_t r;
  fifo_regs_t next_r;
  logic push;
  logic pop;

  // honest flags straight from the count
  assign wr_ready = (r.count != LW'(DEPTH));
  assign rd_valid = (r.count != '0);
  assign rd_data = r.mem[r.rptr];
  assign level = r.count;
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;

  // pointer and count update, clear wins over traffic
  always_comb
  begin
    next_r = r;
    if (push)
    begin
      next_r.mem[r.wptr] = wr_data;
      next_r.wptr = (r.wptr == AW'(DEPTH-1)) ? '0 : r.wptr + AW'(1);
    end
    if (pop)
    begin
      next_r.rptr = (r.rptr == AW'(DEPTH-1)) ? '0 : r.rptr + AW'(1);
    end
    next_r.count = r.count + LW'(push) - LW'(pop);
    if (clear)
    begin
      next_r.wptr = '0;
      next_r.rptr = '0;
      next_r.count = '0;
    end
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      r <= '0;
    else
      r <= next_r;
  end

  // count never passes the depth
  AST_FIFO_BOUND: assert property (@(posedge clk_sys) disable iff (!resetn)
    r.count <= LW'(DEPTH)) else $error("fifo count above depth");
endmodule : rm_column_fifo
`default_nettype wire

// *** core/rm_rate_match.sv ***
// four lane receive rate match fifo with apb registers
// Notes on behaviour
// - the fifo absorbs up to 200 ppm total offset between far transmitter and local clock.
// - rate matching waits for sync on all four lanes and for channel alignment.
// - whole idle columns are deleted or inserted, as many as needed, to avoid overrun or underrun.
// - each deleted column raises the deletion flag on all four lanes for one cycle.
// - each inserted column raises the insertion flag on all four lanes for one cycle.
// - on full or empty no code group is inserted or deleted to recover.
// - full and empty flags stay up until rx_digital_reset clears them.
`timescale 1ns/100ps
`default_nettype none
`include "rm_map.svh"
module rm_rate_match
  import rm_pkg::*;
#(
  parameter int DEPTH = `RM_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic rx_clk_link,
  input wire logic [31:0] rx_lane_data,
  input wire logic [3:0] rx_lane_kchar,
  input wire logic [3:0] rx_sync_status,
  input wire logic rx_channel_aligned,
  input wire logic rx_digital_reset,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] rm_data,
  output logic [3:0] rm_kchar,
  output logic rm_valid,
  output logic [3:0] rm_deleted,
  output logic [3:0] rm_inserted,
  output logic [3:0] rm_fifo_full,
  output logic [3:0] rm_fifo_empty
);
  localparam int DW = 8*`RM_LANES;
  localparam int CW = DW + `RM_LANES;
  localparam int LW = $clog2(DEPTH+1);
  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic [CW-1:0] dat_s1;
    logic [CW-1:0] dat_s2;
    logic [3:0] sync_s1;
    logic [3:0] sync_s2;
    logic algn_s1;
    logic algn_s2;
    rm_state_t state;
    logic [7:0] phase;
    logic ctrl_en;
    logic [LW-1:0] wm_high;
    logic [LW-1:0] wm_low;
    logic [15:0] del_cnt;
    logic [15:0] ins_cnt;
    logic [31:0] out_data;
    logic [3:0] out_kchar;
    logic out_valid;
    logic [3:0] deleted;
    logic [3:0] inserted;
    logic [3:0] full;
    logic [3:0] empty;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rm_regs_t;
  rm_regs_t r;
  rm_regs_t next_r;
  logic fifo_wr_valid;
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic fifo_clear;
  logic [CW-1:0] fifo_rd_data;
  logic [LW-1:0] fifo_level;
  logic [`RM_LANES-1:0] lane_idle_in;
  logic [`RM_LANES-1:0] lane_idle_head;
  logic col_idle;
  logic head_idle;
  logic aligned;
  logic link_edge;
  logic rd_tick;
  logic [7:0] phase_sum;

  // idle code check per lane on the incoming column and the fifo head
  genvar g;
  generate
    for (g = 0; g < `RM_LANES; g++)
    begin : g_lane
      assign lane_idle_in[g] = r.dat_s2[DW+g] && (r.dat_s2[8*g +: 8] == `RM_IDLE_CODE);
      assign lane_idle_head[g] = fifo_rd_data[DW+g] && (fifo_rd_data[8*g +: 8] == `RM_IDLE_CODE);
    end
  endgenerate

  // a column counts only when every lane carries the idle code
  assign col_idle = &lane_idle_in;
  assign head_idle = &lane_idle_head;
  assign aligned = (&r.sync_s2) && r.algn_s2;
  assign link_edge = r.clk_s2 && !r.clk_s3;
  assign phase_sum = r.phase + `RM_CLK_PERIOD_NS;
  assign rd_tick = (phase_sum >= `RM_LINK_PERIOD_NS);

  // the column store between recovered and local rate
  rm_column_fifo #(
    .WIDTH(CW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clear(fifo_clear),
    .wr_valid(fifo_wr_valid),
    .wr_ready(fifo_wr_ready),
    .wr_data(r.dat_s2),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_rd_ready),
    .rd_data(fifo_rd_data),
    .level(fifo_level)
  );

  // next state: synchronisers, rate match, apb slave
  always_comb
  begin
    next_r = r;
    fifo_wr_valid = 1'b0;
    fifo_rd_ready = 1'b0;
    fifo_clear = 1'b0;
    // two flop synchronisers for the link pins
    next_r.clk_s1 = rx_clk_link;
    next_r.clk_s2 = r.clk_s1;
    next_r.clk_s3 = r.clk_s2;
    next_r.dat_s1 = {rx_lane_kchar, rx_lane_data};
    next_r.dat_s2 = r.dat_s1;
    next_r.sync_s1 = rx_sync_status;
    next_r.sync_s2 = r.sync_s1;
    next_r.algn_s1 = rx_channel_aligned;
    next_r.algn_s2 = r.algn_s1;
    // local read rate as a fractional divider
    next_r.phase = rd_tick ? phase_sum - `RM_LINK_PERIOD_NS : phase_sum;
    next_r.deleted = 4'h0;
    next_r.inserted = 4'h0;
    next_r.out_valid = 1'b0;
    // mode control
    case (r.state)
      st_wait_align:
      begin
        fifo_clear = 1'b1;
        if (aligned && r.ctrl_en)
          next_r.state = st_priming;
      end
      st_priming:
      begin
        if (!aligned || !r.ctrl_en)
          next_r.state = st_wait_align;
        else if (fifo_level >= LW'(`RM_PRIME_LEVEL))
          next_r.state = st_matching;
      end
      st_matching:
      begin
        if (!aligned || !r.ctrl_en)
          next_r.state = st_wait_align;
      end
      st_halted:
      begin
        next_r.state = st_halted;
      end
      default:
      begin
        next_r.state = st_wait_align;
      end
    endcase
    // write side, one column per recovered clock edge
    if ((r.state == st_priming || r.state == st_matching) && aligned && r.ctrl_en && link_edge)
    begin
      if (r.state == st_matching && col_idle && fifo_level >= r.wm_high)
      begin
        next_r.deleted = 4'hf;
        next_r.del_cnt = r.del_cnt + 16'h0001;
      end
      else if (!fifo_wr_ready)
      begin
        next_r.state = st_halted;
        next_r.full = 4'hf;
      end
      else
        fifo_wr_valid = 1'b1;
    end
    // read side, one column per local tick
    if (r.state == st_matching && aligned && r.ctrl_en && rd_tick)
    begin
      if (!fifo_rd_valid)
      begin
        next_r.state = st_halted;
        next_r.empty = 4'hf;
      end
      else
      begin
        next_r.out_valid = 1'b1;
        next_r.out_data = fifo_rd_data[DW-1:0];
        next_r.out_kchar = fifo_rd_data[CW-1:DW];
        if (head_idle && fifo_level <= r.wm_low)
        begin
          next_r.inserted = 4'hf;
          next_r.ins_cnt = r.ins_cnt + 16'h0001;
        end
        else
          fifo_rd_ready = 1'b1;
      end
    end
    // fabric reset of the receive path
    if (rx_digital_reset)
    begin
      fifo_clear = 1'b1;
      next_r.state = st_wait_align;
      next_r.full = 4'h0;
      next_r.empty = 4'h0;
      next_r.deleted = 4'h0;
      next_r.inserted = 4'h0;
      next_r.out_valid = 1'b0;
      fifo_wr_valid = 1'b0;
      fifo_rd_ready = 1'b0;
    end
    // apb slave, answers one cycle into the access phase
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    if (psel && penable && !r.pready)
    begin
      next_r.pready = 1'b1;
      if (!pwrite)
        next_r.prdata = 32'h0000_0000;
      if (paddr == `RM_REG_CTRL)
      begin
        if (pwrite)
          next_r.ctrl_en = pwdata[`RM_CTRL_EN];
        else
          next_r.prdata[`RM_CTRL_EN] = r.ctrl_en;
      end
      else if (paddr == `RM_REG_STATUS)
      begin
        if (!pwrite)
        begin
          next_r.prdata[`RM_ST_FULL] = r.full[0];
          next_r.prdata[`RM_ST_EMPTY] = r.empty[0];
          next_r.prdata[`RM_ST_STATE_LSB +: 2] = r.state;
          next_r.prdata[`RM_ST_ALIGNED] = aligned;
          next_r.prdata[`RM_ST_LEVEL_LSB +: LW] = fifo_level;
        end
      end
      else if (paddr == `RM_REG_WMARK)
      begin
        if (pwrite)
        begin
          next_r.wm_high = pwdata[`RM_WM_HIGH_LSB +: LW];
          next_r.wm_low = pwdata[`RM_WM_LOW_LSB +: LW];
        end
        else
        begin
          next_r.prdata[`RM_WM_HIGH_LSB +: LW] = r.wm_high;
          next_r.prdata[`RM_WM_LOW_LSB +: LW] = r.wm_low;
        end
      end
      else if (paddr == `RM_REG_DEL_CNT)
      begin
        if (!pwrite)
          next_r.prdata[15:0] = r.del_cnt;
      end
      else if (paddr == `RM_REG_INS_CNT)
      begin
        if (!pwrite)
          next_r.prdata[15:0] = r.ins_cnt;
      end
      else
        next_r.pslverr = 1'b1;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      r <= '0;
      r.state <= st_wait_align;
      r.ctrl_en <= `RM_CTRL_EN_RESET;
      r.wm_high <= LW'(`RM_WM_HIGH_RESET);
      r.wm_low <= LW'(`RM_WM_LOW_RESET);
    end
    else
      r <= next_r;
  end

  // outputs straight from the state register
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign rm_data = r.out_data;
  assign rm_kchar = r.out_kchar;
  assign rm_valid = r.out_valid;
  assign rm_deleted = r.deleted;
  assign rm_inserted = r.inserted;
  assign rm_fifo_full = r.full;
  assign rm_fifo_empty = r.empty;

  // level one cycle back, for the deletion check
  logic [LW-1:0] level_prev;
  always_ff @(posedge clk_sys)
  begin
    level_prev <= fifo_level;
  end

  // checks on the rate match behaviour
  AST_MATCH_NEEDS_ALIGN: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rm_deleted != 4'h0 || rm_inserted != 4'h0) |-> $past(aligned) && $past(r.state) == st_matching)
    else $error("column edited without alignment");
  AST_DEL_PULSE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rm_deleted != 4'h0) |-> (rm_deleted == 4'hf) ##1 (rm_deleted == 4'h0))
    else $error("deletion flag not one cycle on all lanes");
  AST_INS_PULSE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rm_inserted != 4'h0) |-> (rm_inserted == 4'hf) ##1 (rm_inserted == 4'h0))
    else $error("insertion flag not one cycle on all lanes");
  AST_DEL_CAUSE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (link_edge && col_idle && aligned && r.ctrl_en && r.state == st_matching
     && fifo_level >= r.wm_high && !rx_digital_reset) |=> rm_deleted == 4'hf
     && fifo_level <= level_prev)
    else $error("idle column above high mark not deleted");
  AST_INS_CAUSE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rd_tick && head_idle && fifo_rd_valid && aligned && r.ctrl_en && r.state == st_matching
     && fifo_level <= r.wm_low && !rx_digital_reset) |=> rm_inserted == 4'hf && rm_valid)
    else $error("idle column below low mark not inserted");
  AST_FULL_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rm_fifo_full[0] && !rx_digital_reset) |=> rm_fifo_full == 4'hf)
    else $error("full flag dropped before digital reset");
  AST_EMPTY_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rm_fifo_empty[0] && !rx_digital_reset) |=> rm_fifo_empty == 4'hf)
    else $error("empty flag dropped before digital reset");
  AST_NO_RECOVER: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rm_fifo_full != 4'h0 || rm_fifo_empty != 4'h0) |=>
    (rm_deleted == 4'h0 && rm_inserted == 4'h0 && !rm_valid)[*2])
    else $error("columns edited after full or empty");
  AST_FULL_CAUSE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (link_edge && !col_idle && !fifo_wr_ready && aligned && r.ctrl_en
     && r.state == st_matching && !rx_digital_reset) |=> rm_fifo_full == 4'hf)
    else $error("write into full fifo not flagged");
  AST_DIG_RESET: assert property (@(posedge clk_sys) disable iff (!resetn)
    rx_digital_reset |=> rm_fifo_full == 4'h0 && rm_fifo_empty == 4'h0 && rm_deleted == 4'h0
    && rm_inserted == 4'h0 && r.state == st_wait_align ##1 fifo_level == '0)
    else $error("digital reset did not clear the receive path");
endmodule : rm_rate_match
`default_nettype wire

// *** tb/rm_link_model.sv ***
// upstream transmitter model: recovered link clock and lane columns
`timescale 1ns/100ps
`default_nettype none
module rm_link_model (
  input wire logic idle_only,
  input wire logic [15:0] half_t,
  output logic rx_clk_link,
  output logic [31:0] rx_lane_data,
  output logic [3:0] rx_lane_kchar
);
  logic [7:0] seq = 8'h00;
  // free running recovered clock, half period in 100 ps steps
  initial
  begin
    rx_clk_link = 1'b0;
    forever
    begin
      #(half_t * 0.1);
      rx_clk_link = ~rx_clk_link;
    end
  end
  // new column on each falling edge, stable at the rising edge
  always @(negedge rx_clk_link)
  begin
    seq <= seq + 8'h01;
    if (idle_only)
    begin
      rx_lane_data <= {4{8'h1c}};
      rx_lane_kchar <= 4'hf;
    end
    else
    begin
      rx_lane_data <= {4{seq}};
      rx_lane_kchar <= 4'h0;
    end
  end
endmodule : rm_link_model
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench of the rate match fifo
`timescale 1ns/100ps
`default_nettype none
`include "rm_map.svh"
`define CHK(g, e) check(32'(g), 32'(e))
module tb
  import rm_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic rx_clk_link;
  logic [31:0] rx_lane_data, prdata, rm_data, rdv;
  logic [3:0] rx_lane_kchar, rm_kchar, rm_deleted, rm_inserted, del_prev, ins_prev;
  logic [3:0] rx_sync_status = 4'h0;
  logic [3:0] rm_fifo_full, rm_fifo_empty;
  logic rx_channel_aligned = 1'b0;
  logic rx_digital_reset = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic pready, pslverr, rm_valid, errv;
  logic idle_only = 1'b1;
  logic [15:0] half_t = 16'h0271;
  logic [7:0] last_byte = 8'h00;
  logic last_ok = 1'b0;
  int errors = 0, checked = 0, del_seen = 0, ins_seen = 0, valid_seen = 0;

  always #5 clk_sys = ~clk_sys;

  rm_rate_match i_rm_rate_match (
    .clk_sys(clk_sys), .resetn(resetn), .rx_clk_link(rx_clk_link),
    .rx_lane_data(rx_lane_data), .rx_lane_kchar(rx_lane_kchar),
    .rx_sync_status(rx_sync_status), .rx_channel_aligned(rx_channel_aligned),
    .rx_digital_reset(rx_digital_reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rm_data(rm_data), .rm_kchar(rm_kchar), .rm_valid(rm_valid), .rm_deleted(rm_deleted),
    .rm_inserted(rm_inserted), .rm_fifo_full(rm_fifo_full), .rm_fifo_empty(rm_fifo_empty)
  );
  rm_link_model i_rm_link_model (
    .idle_only(idle_only), .half_t(half_t), .rx_clk_link(rx_clk_link),
    .rx_lane_data(rx_lane_data), .rx_lane_kchar(rx_lane_kchar)
  );

  task print_verdict;
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // one apb transfer, result left in rdv and errv
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
    begin
      errors++;
      print_verdict();
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic bit reached(input int sel, input int target);
    case (sel)
      0: return del_seen >= target;
      1: return ins_seen >= target;
      2: return rm_fifo_full === 4'hf;
      default: return rm_fifo_empty === 4'hf;
    endcase
  endfunction : reached

  task wait_until(input int sel, input int target);
    int n;
    n = 0;
    while (!reached(sel, target) && n < 40000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 40000)
    begin
      errors++;
      print_verdict();
    end
  endtask : wait_until

  // flag pulses: all lanes together, one cycle each
  always @(posedge clk_sys)
  begin
    if (resetn === 1'b1 && rm_deleted !== 4'h0)
    begin
      `CHK(rm_deleted, 4'hf);
      `CHK(del_prev, 4'h0);
      del_seen++;
    end
    if (resetn === 1'b1 && rm_inserted !== 4'h0)
    begin
      `CHK(rm_inserted, 4'hf);
      `CHK(ins_prev, 4'h0);
      `CHK({rm_valid, rm_kchar}, 5'h1f);
      `CHK(rm_data, 32'h1c1c1c1c);
      ins_seen++;
    end
    if (rm_valid === 1'b1)
      valid_seen++;
    // data columns pass in order, lanes together, until a fabric reset
    if (rx_digital_reset === 1'b1)
      last_ok <= 1'b0;
    else if (resetn === 1'b1 && rm_valid === 1'b1)
    begin
      if (last_ok && rm_kchar === 4'h0)
        `CHK(rm_data, {4{last_byte + 8'h01}});
      last_ok <= (rm_kchar === 4'h0);
      last_byte <= rm_data[7:0];
    end
    del_prev <= rm_deleted;
    ins_prev <= rm_inserted;
  end

  task t_regs;
    apb(1'b0, `RM_REG_WMARK, 32'h0);
    `CHK(rdv, 32'h0000040c);
    apb(1'b1, 12'hff0, 32'h1);
    `CHK(errv, 1'b1);
    apb(1'b1, `RM_REG_CTRL, 32'h1);
    apb(1'b0, `RM_REG_STATUS, 32'h0);
    `CHK(rdv, 32'h0);
  endtask : t_regs

  task t_no_align;
    int i;
    for (i = 0; i < 3; i++)
    begin
      if (i == 2)
        apb(1'b1, `RM_REG_CTRL, 32'h0);
      rx_sync_status <= (i == 0) ? 4'h7 : 4'hf;
      rx_channel_aligned <= (i != 1);
      cyc(400);
      `CHK(valid_seen, 0);
      apb(1'b0, `RM_REG_STATUS, 32'h0);
      `CHK(rdv[3:2], st_wait_align);
    end
    apb(1'b1, `RM_REG_CTRL, 32'h1);
  endtask : t_no_align

  task t_delete;
    rx_sync_status <= 4'hf;
    rx_channel_aligned <= 1'b1;
    half_t <= 16'h023f;
    wait_until(0, 3);
    idle_only <= 1'b0;
    half_t <= 16'h0271;
    cyc(150);
    apb(1'b0, `RM_REG_DEL_CNT, 32'h0);
    `CHK(rdv, del_seen);
    apb(1'b0, `RM_REG_STATUS, 32'h0);
    `CHK(rdv[1:0], 2'h0);
  endtask : t_delete

  task t_insert;
    idle_only <= 1'b1;
    half_t <= 16'h02a3;
    wait_until(1, ins_seen + 3);
    idle_only <= 1'b0;
    half_t <= 16'h0271;
    cyc(150);
    apb(1'b0, `RM_REG_INS_CNT, 32'h0);
    `CHK(rdv, ins_seen);
  endtask : t_insert

  // fabric reset after a full or empty flag
  task fabric_reset;
    int v;
    rx_digital_reset <= 1'b1;
    @(posedge clk_sys);
    rx_digital_reset <= 1'b0;
    cyc(2);
    `CHK({rm_fifo_full, rm_fifo_empty}, 8'h00);
    v = valid_seen;
    cyc(20);
    `CHK(valid_seen, v);
  endtask : fabric_reset

  task t_full;
    int d;
    d = del_seen;
    half_t <= 16'h023f;
    wait_until(2, 0);
    cyc(40);
    `CHK(rm_fifo_full, 4'hf);
    `CHK(del_seen, d);
    apb(1'b0, `RM_REG_STATUS, 32'h0);
    `CHK(rdv[0], 1'b1);
    fabric_reset();
  endtask : t_full

  task t_empty;
    int i;
    i = ins_seen;
    half_t <= 16'h02a3;
    wait_until(3, 0);
    cyc(40);
    `CHK(rm_fifo_empty, 4'hf);
    `CHK(ins_seen, i);
    fabric_reset();
  endtask : t_empty

  initial
  begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    cyc(1);
    `CHK({pready, rm_valid, rm_deleted, rm_inserted, rm_fifo_full, rm_fifo_empty}, 18'h0);
    t_regs();
    t_no_align();
    t_delete();
    t_insert();
    t_full();
    t_empty();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
